// ===== core/err_report_defines.svh
// Constants for the user error-report port: header field positions and widths.
// Assumes inclusion by the package and by the core end of the port.
// Functional notes
// - Unsupported or abort reports honoured only when ready; posted ones are logged and flagged without waiting for ready
// - Locked qualifier marks erroring transaction locked
// - Legacy mode: locked with UR/CA gives locked completion
// - Non-legacy mode: device infers locked completion itself
// - User supplies 128-bit header log with error
// - Header-log-set raised when log occupied or full; the core raises it only when full: one entry, or two with multi_header set
// - 5-bit message number copied into root status
// - User keeps message number valid for MSI/MSI-X
// - User refreshes number when multiple-message-enable changes
// - Timeout and correctable reports only in D0
// - User presents completion header with every error
// - Posted qualifier marks erroring transaction posted
`ifndef ERR_REPORT_DEFINES_SVH
`define ERR_REPORT_DEFINES_SVH
`define CPL_HDR_W 48
`define HDR_LOG_W 128
`define MSGNUM_W 5
`define LADDR_HI 47
`define LADDR_LO 41
`define BCNT_HI 40
`define BCNT_LO 29
`define TC_HI 28
`define TC_LO 26
`define ATTR_HI 25
`define ATTR_LO 24
`define REQID_HI 23
`define REQID_LO 8
`define TAG_HI 7
`define TAG_LO 0
`define CPL_BUSY_CYCLES 4'h4
`define HDR_LOG_DEPTH 2'h2
`endif

// ===== core/err_report_pkg.sv
// Types shared by both ends of the user error-report port.
// Assumes the defines header is on the include path.
`include "err_report_defines.svh"
package err_report_pkg;
  typedef enum logic [1:0]
  {
    CPL_STATUS_SC = 2'b00,
    CPL_STATUS_UR = 2'b01,
    CPL_STATUS_CA = 2'b10
  } cpl_status_t;

  typedef struct packed
  {
    logic [6:0] lower_addr;
    logic [11:0] byte_count;
    logic [2:0] tc;
    logic [1:0] attr;
    logic [15:0] requester_id;
    logic [7:0] tag;
  } cpl_hdr_t;

  typedef enum logic [1:0]
  {
    CPL_IDLE = 2'b00,
    CPL_BUSY = 2'b01
  } cpl_state_t;
endpackage : err_report_pkg

// ===== core/err_report_if.sv
// Interface joining the user application and the core's error-report port.
// Assumes one clock shared by both parties.
interface err_report_if;
  import err_report_pkg::*;
  logic err_unsupported_request_report;
  logic err_cpl_abort;
  logic err_cpl_timeout;
  logic err_cor;
  logic err_posted;
  logic err_locked;
  logic [47:0] err_cpl_header;
  logic [127:0] err_header_log;
  logic [4:0] aer_msgnum;
  logic err_cpl_ready;
  logic err_header_log_set;

  modport core
  (
    input err_unsupported_request_report, err_cpl_abort, err_cpl_timeout, err_cor,
    input err_posted, err_locked, err_cpl_header, err_header_log, aer_msgnum,
    output err_cpl_ready, err_header_log_set
  );
  modport user
  (
    output err_unsupported_request_report, err_cpl_abort, err_cpl_timeout, err_cor,
    output err_posted, err_locked, err_cpl_header, err_header_log, aer_msgnum,
    input err_cpl_ready, err_header_log_set
  );
endinterface : err_report_if

// ===== core/cpl_builder.sv
// Builds a completion descriptor from an accepted non-posted error report.
// Assumes the caller only pulses start while it is idle.
module cpl_builder
  import err_report_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // Request
  input wire logic start,
  input wire logic [47:0] header,
  input wire cpl_status_t status,
  input wire logic locked,
  // Result
  output logic cpl_valid,
  output logic [47:0] cpl_header,
  output cpl_status_t cpl_status,
  output logic cpl_locked
);
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cpl_valid <= 1'b0;
      cpl_header <= 48'h0000_0000_0000;
      cpl_status <= CPL_STATUS_SC;
      cpl_locked <= 1'b0;
    end
    else if (ce)
    begin
      cpl_valid <= start;
      if (start)
      begin
        cpl_header <= header;
        cpl_status <= status;
        cpl_locked <= locked;
      end
    end
  end
endmodule : cpl_builder

// ===== core/err_report_core.sv
// Core end of the error-report port: accepts reports, builds completions,
// tracks the header log and holds the AER interrupt message number.
// Assumes the user end is on the same clock; its outputs come from registers, except aer_msgnum, which passes msgnum straight through.
module err_report_core
  import err_report_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // Port to the user application
  err_report_if.core port,
  // Configuration
  input wire logic legacy_mode,
  input wire logic multi_header,
  input wire logic locked_request_seen,
  input wire logic header_log_release,
  // Results
  output logic cpl_valid,
  output logic [47:0] cpl_header,
  output cpl_status_t cpl_status,
  output logic cpl_locked,
  output logic posted_err_event,
  output logic any_err_event,
  output logic [4:0] root_err_msgnum,
  output logic [127:0] logged_header,
  output logic err_cpl_ready,
  output logic err_header_log_set
);
  `include "err_report_defines.svh"

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Unsupported request outranks abort when both are raised
  function automatic cpl_status_t report_status
  (
    input logic ur
  );
    return ur ? CPL_STATUS_UR : CPL_STATUS_CA;
  endfunction : report_status

  // Log occupancy after one cycle; a take and a release may fall together
  function automatic logic [1:0] next_log_count
  (
    input logic [1:0] count,
    input logic take,
    input logic drop
  );
    logic [1:0] result;
    result = count;
    if (take)
    begin
      result = result + 2'h1;
    end
    if (drop)
    begin
      result = result - 2'h1;
    end
    return result;
  endfunction : next_log_count

  // Busy countdown: reload on acceptance, stop at zero
  function automatic logic [3:0] next_busy
  (
    input logic start,
    input logic [3:0] count
  );
    logic [3:0] result;
    if (start)
    begin
      result = `CPL_BUSY_CYCLES;
    end
    else if (count != 4'h0)
    begin
      result = count - 4'h1;
    end
    else
    begin
      result = 4'h0;
    end
    return result;
  endfunction : next_busy

  ////////////////////////////////////////////////////////////////////////////
  // Report decode
  cpl_state_t state;
  cpl_state_t next_state;
  logic [3:0] busy_cnt;
  logic [1:0] log_count;
  wire any_err = port.err_unsupported_request_report | port.err_cpl_abort |
                 port.err_cpl_timeout | port.err_cor;
  wire np_report = (port.err_unsupported_request_report | port.err_cpl_abort) &
                   ~port.err_posted;
  // A report seen while busy is refused; the user end keeps holding it
  wire accept = np_report & err_cpl_ready & (state == CPL_IDLE);
  // Locked: the user's qualifier in legacy mode, own detection otherwise
  wire cpl_lock = legacy_mode ? port.err_locked : locked_request_seen;
  cpl_status_t req_status;
  assign req_status = report_status(port.err_unsupported_request_report);
  wire [1:0] log_limit = multi_header ? `HDR_LOG_DEPTH : 2'h1;
  wire log_full = (log_count >= log_limit);
  wire log_take = any_err & ~log_full;
  wire log_drop = header_log_release & (log_count != 2'h0);
  wire [1:0] next_log = next_log_count(log_count, log_take, log_drop);

  ////////////////////////////////////////////////////////////////////////////
  // Completion engine
  always_comb
  begin
    next_state = state;
    case (state)
      CPL_IDLE: if (accept) next_state = CPL_BUSY;
      CPL_BUSY: if (busy_cnt == 4'h1) next_state = CPL_IDLE;
      default: next_state = CPL_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= CPL_IDLE;
      busy_cnt <= 4'h0;
    end
    else if (ce)
    begin
      state <= next_state;
      busy_cnt <= next_busy(accept, busy_cnt);
    end
  end

  // Ready is low from acceptance until the countdown expires
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      err_cpl_ready <= 1'b0;
    end
    else if (ce)
    begin
      err_cpl_ready <= (next_state == CPL_IDLE);
    end
  end

  cpl_builder builder
  (
    .clk(clk),
    .arst_n(arst_n),
    .ce(ce),
    .start(accept),
    .header(port.err_cpl_header),
    .status(req_status),
    .locked(cpl_lock),
    .cpl_valid(cpl_valid),
    .cpl_header(cpl_header),
    .cpl_status(cpl_status),
    .cpl_locked(cpl_locked)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Header log occupancy and its full flag
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      log_count <= 2'h0;
      err_header_log_set <= 1'b0;
    end
    else if (ce)
    begin
      log_count <= next_log;
      err_header_log_set <= (next_log >= log_limit);
    end
  end

  // Latest header that found room in the log
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      logged_header <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
    end
    else if (ce && log_take)
    begin
      logged_header <= port.err_header_log;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Message number and error events
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      root_err_msgnum <= 5'h00;
    end
    else if (ce)
    begin
      root_err_msgnum <= port.aer_msgnum;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      posted_err_event <= 1'b0;
      any_err_event <= 1'b0;
    end
    else if (ce)
    begin
      posted_err_event <= any_err & port.err_posted;
      any_err_event <= any_err;
    end
  end

  assign port.err_cpl_ready = err_cpl_ready;
  assign port.err_header_log_set = err_header_log_set;
endmodule : err_report_core

// ===== core/err_report_user.sv
// User end: turns one-cycle error requests into reports; non-posted UR/abort held until taken, posted ones for one cycle.
// Assumes the core end shares the clock.
module err_report_user
  import err_report_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  // Port to the core
  err_report_if.user port,
  // User requests
  input wire logic req_ur,
  input wire logic req_abort,
  input wire logic req_timeout,
  input wire logic req_cor,
  input wire logic req_posted,
  input wire logic req_locked,
  input wire logic in_d0,
  input wire cpl_hdr_t req_header,
  input wire logic [127:0] req_header_log,
  input wire logic [4:0] msgnum,
  // Status
  output logic pending,
  output logic log_set
);
  logic hold_ur;
  logic hold_abort;
  logic hold_posted;
  logic hold_locked;
  logic [47:0] hold_hdr;
  logic [127:0] hold_log;
  logic pulse_to;
  logic pulse_cor;
  wire np_hold = (hold_ur | hold_abort) & ~hold_posted;
  wire taken = np_hold & port.err_cpl_ready;
  wire load = ~(hold_ur | hold_abort) & (req_ur | req_abort);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hold_ur <= 1'b0;
      hold_abort <= 1'b0;
      hold_posted <= 1'b0;
      hold_locked <= 1'b0;
      hold_hdr <= 48'h0000_0000_0000;
      hold_log <= 128'h0000_0000_0000_0000_0000_0000_0000_0000;
      pulse_to <= 1'b0;
      pulse_cor <= 1'b0;
      log_set <= 1'b0;
    end
    else if (ce)
    begin
      if (load)
      begin
        hold_ur <= req_ur;
        hold_abort <= req_abort & ~req_ur;
        hold_posted <= req_posted;
        hold_locked <= req_locked;
        hold_hdr <= req_header;
        hold_log <= req_header_log;
      end
      else if (taken || hold_posted)
      begin
        hold_ur <= 1'b0;
        hold_abort <= 1'b0;
      end
      pulse_to <= req_timeout & in_d0;
      pulse_cor <= req_cor & in_d0;
      log_set <= port.err_header_log_set;
    end
  end

  assign pending = hold_ur | hold_abort;
  assign port.err_unsupported_request_report = hold_ur;
  assign port.err_cpl_abort = hold_abort;
  assign port.err_cpl_timeout = pulse_to;
  assign port.err_cor = pulse_cor;
  assign port.err_posted = hold_posted & (hold_ur | hold_abort);
  assign port.err_locked = hold_locked & (hold_ur | hold_abort);
  assign port.err_cpl_header = hold_hdr;
  assign port.err_header_log = hold_log;
  assign port.aer_msgnum = msgnum;
endmodule : err_report_user

// ===== test/err_report_monitor.sv
// Checker on the error-report port between the user end and the core end.
// Assumes one clock; instanced by the bench beside the interface.
module err_report_monitor
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Port
  input wire logic err_unsupported_request_report,
  input wire logic err_cpl_abort,
  input wire logic err_posted,
  input wire logic err_locked,
  input wire logic [47:0] err_cpl_header,
  input wire logic err_cpl_ready,
  input wire logic err_header_log_set
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  wire ur = err_unsupported_request_report;
  wire rep = ur || err_cpl_abort;
  wire np = rep && !err_posted;
  ////////////////////////////////////////////////////////////////
  a_take_drops_ready: assert property (np && err_cpl_ready |=> !err_cpl_ready)
    else $error("ready high after take");
  a_busy_four: assert property ($fell(err_cpl_ready) |-> !err_cpl_ready [*4] ##1 err_cpl_ready)
    else $error("busy time wrong");
  a_held_refused: assert property (np && !err_cpl_ready |=> rep)
    else $error("report dropped");
  a_taken_released: assert property (np && err_cpl_ready |=> !rep)
    else $error("report kept");
  a_header_stable: assert property (np && !err_cpl_ready |=> $stable(err_cpl_header))
    else $error("header moved");
  a_locked_alone: assert property (err_locked |-> rep)
    else $error("lone locked");
  a_posted_alone: assert property (err_posted |-> rep)
    else $error("lone posted");
  a_ready_reset: assert property ($rose(arst_n) |=> err_cpl_ready)
    else $error("ready late");
  cover property (np && err_cpl_ready);
  cover property (err_locked && ur && err_cpl_ready);
  cover property ($rose(err_header_log_set));
endmodule : err_report_monitor

// ===== test/pcie_user_error_report_port_tb.sv
// Bench: both ends joined by the port, random and corner reports.
// Assumes the core files are compiled first.
module pcie_user_error_report_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import err_report_pkg::*;
  logic clk = 1'h0, arst_n = 1'h0, ce = 1'h1, legacy = 1'h0, multi = 1'h0;
  logic seen = 1'h0, rel = 1'h1, r_ur = 1'h0, r_ab = 1'h0, r_to = 1'h0;
  logic r_cor = 1'h0, r_po = 1'h0, r_lk = 1'h0, d0 = 1'h1, got;
  cpl_hdr_t hdr = '0;
  logic [127:0] hlog = '0, lh;
  logic [4:0] num = '0, rnum;
  logic cv, cl, pe, ae, lset, pend, uset;
  logic [47:0] ch;
  cpl_status_t cs;
  logic [31:0] seed = 32'h0000_2bbf, v;
  int fails = 0, comparisons = 0, cyc = 0;
  err_report_if link ();
  err_report_core u_err_report_core (.clk(clk), .arst_n(arst_n), .ce(ce), .port(link.core),
    .legacy_mode(legacy), .multi_header(multi), .locked_request_seen(seen),
    .header_log_release(rel), .cpl_valid(cv), .cpl_header(ch), .cpl_status(cs),
    .cpl_locked(cl), .posted_err_event(pe), .any_err_event(ae), .root_err_msgnum(rnum),
    .logged_header(lh), .err_cpl_ready(), .err_header_log_set(lset));
  err_report_user u_err_report_user (.clk(clk), .arst_n(arst_n), .ce(ce), .port(link.user),
    .req_ur(r_ur), .req_abort(r_ab), .req_timeout(r_to), .req_cor(r_cor), .req_posted(r_po),
    .req_locked(r_lk), .in_d0(d0), .req_header(hdr), .req_header_log(hlog), .msgnum(num),
    .pending(pend), .log_set(uset));
  err_report_monitor u_err_report_monitor (.clk(clk), .arst_n(arst_n),
    .err_unsupported_request_report(link.err_unsupported_request_report),
    .err_cpl_abort(link.err_cpl_abort), .err_posted(link.err_posted),
    .err_locked(link.err_locked), .err_cpl_header(link.err_cpl_header),
    .err_cpl_ready(link.err_cpl_ready), .err_header_log_set(link.err_header_log_set));
  ////////////////////////////////////////////////////////////////
  always #10 clk = ~clk;
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fails++;
      conclude();
    end
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic cpl_status_t f_status(logic ur);
    return ur ? CPL_STATUS_UR : CPL_STATUS_CA;
  endfunction : f_status
  function automatic logic f_lock(logic lg, logic lk, logic sn);
    return lg ? lk : sn;
  endfunction : f_lock
  task automatic conclude();
    if (fails == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  task automatic check(input logic [127:0] a, input logic [127:0] b);
    comparisons++;
    if (a !== b)
    begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, a, b);
    end
  endtask : check
  task automatic tick();
    @(posedge clk);
    #2;
  endtask : tick
  task automatic rst();
    arst_n = 1'h0;
    repeat (4) tick();
    arst_n = 1'h1;
    repeat (2) tick();
  endtask : rst
  // One report; w low presents it while the core may still be busy
  task automatic report(input logic ur, ab, po, lk, w);
    int n;
    n = 0;
    while (w && link.err_cpl_ready !== 1'h1 && n < 20)
    begin
      tick();
      n++;
    end
    {r_ur, r_ab, r_po, r_lk} = {ur, ab, po, lk};
    tick();
    {r_ur, r_ab, r_po, r_lk} = 4'h0;
    check(pend, 1'h1);
    n = 0;
    while (cv !== 1'h1 && pe !== 1'h1 && n < 14)
    begin
      tick();
      n++;
    end
    check({cv, pe}, {!po, po});
    check(pend, 1'h0);
    if (!po)
    begin
      check(cs, f_status(ur));
      check(cl, f_lock(legacy, lk, seen));
      check(ch[47:41], hdr.lower_addr);
      check(ch, hdr);
    end
    check(rnum, num);
  endtask : report
  ////////////////////////////////////////////////////////////////
  initial
  begin
    rst();
    // Corners: both kinds at once, locked, each mode, all-ones header
    hdr = '1;
    for (int k = 0; k < 4; k++)
    begin
      legacy = k[0];
      report(1'h1, 1'h1, 1'h0, k[1], k[0]);
    end
    repeat (60)
    begin
      v = xs();
      {legacy, seen, num} = v[6:0];
      hdr = {v[15:0], xs()};
      hlog = {4{v}};
      report(v[8], v[9] | !v[8], v[10] & v[11], v[12] & !(v[10] & v[11]), v[13]);
    end
    // Timeout and correctable reports, in and out of D0
    for (int k = 0; k < 4; k++)
    begin
      d0 = k[0];
      {r_to, r_cor} = {k[1], !k[1]};
      tick();
      {r_to, r_cor} = 2'h0;
      got = 1'h0;
      repeat (6)
      begin
        tick();
        got |= ae;
      end
      check(got, d0);
    end
    // Header log fills for one and two entries, then drains
    for (int m = 0; m < 2; m++)
    begin
      multi = m[0];
      rel = 1'h0;
      rst();
      for (int i = 0; i < 3; i++)
      begin
        hlog = {4{xs()}};
        report(1'h1, 1'h0, 1'h1, 1'h0, 1'h1);
        tick();
        check(lset, i >= m);
        check(uset, i >= m);
        if (i == 0)
          check(lh, hlog);
      end
      rel = 1'h1;
      repeat (3) tick();
      check(lset, 1'h0);
      check(uset, 1'h0);
    end
    conclude();
  end
endmodule : pcie_user_error_report_port_tb
